// [dv/sram_page_select_tb_top.sv]
// self-checking bench for the sram page select register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module sram_page_select_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic access_valid, stack_access, sram_addr_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] access_offset;
    logic [3:0] pstrb;
    logic [10:0] sram_addr, ea;
    logic [33:0] e;
    logic [15:0] lf = 16'hAF2F;
    logic [33:0] rd_q[$];
    logic [10:0] ad_q[$];
    int err_count = 0;
    int checked = 0;
    sram_page_select sram_page_select_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .access_valid(access_valid), .stack_access(stack_access),
        .access_offset(access_offset), .sram_addr(sram_addr), .sram_addr_valid(sram_addr_valid));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [11:0] ba(input logic [11:0] idx);
        return idx * sram_page_pkg::page_index_scale;
    endfunction : ba
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [33:0] ex);
        rd_q.push_back(ex);
        access_valid <= 1'b0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr_page(input logic [11:0] idx, input logic [2:0] pg);
        apb(1'b1, ba(idx), {29'h0, pg}, {2'b00, 32'h0});
    endtask : wr_page
    task automatic acc(input logic stk, input logic [2:0] pg);
        lf = lfsr_next(lf);
        ad_q.push_back({pg, lf[7:0]});
        access_valid <= 1'b1; stack_access <= stk; access_offset <= lf[7:0];
        @(posedge pclk);
    endtask : acc
    task automatic tally_and_finish;
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------------------------------
    // clock, watchdog, output monitor
    // ----------------------------------------------------------------
    initial begin pclk = 1'b0; forever #2.5 pclk = ~pclk; end
    initial begin repeat (3000) @(posedge pclk); err_count++; tally_and_finish; end
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = rd_q.size() ? rd_q.pop_front() : 34'h3_FFFF_FFFF;
            `CHK("pslverr", e[32], pslverr)
            if (e[33]) `CHK("prdata", e[31:0], prdata)
        end
        if (sram_addr_valid === 1'b1) begin
            ea = ad_q.size() ? ad_q.pop_front() : 11'h7FF;
            `CHK("sram_addr", ea, sram_addr)
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; access_valid = 1'b0; stack_access = 1'b0; access_offset = 8'h00;
        pstrb = 4'hF;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values read back as page 0
        apb(1'b0, ba(sram_page_pkg::normal_page_addr), 32'h0, {2'b10, 32'h0});
        apb(1'b0, ba(sram_page_pkg::stack_page_addr), 32'h0, {2'b10, 32'h0});
        // single page: fields ignored
        wr_page(sram_page_pkg::normal_page_addr, 3'h5);
        wr_page(sram_page_pkg::stack_page_addr, 3'h3);
        acc(1'b0, sram_page_pkg::sole_page);
        acc(1'b1, sram_page_pkg::sole_page);
        wr_page(sram_page_pkg::ctrl_addr, 3'h1);
        for (int p = 0; p < 8; p++) begin
            wr_page(sram_page_pkg::normal_page_addr, p[2:0]);
            wr_page(sram_page_pkg::stack_page_addr, 3'h7 - p[2:0]);
            apb(1'b0, ba(sram_page_pkg::normal_page_addr), 32'h0, {2'b10, 29'h0, p[2:0]});
            apb(1'b0, ba(sram_page_pkg::stack_page_addr), 32'h0,
                {2'b10, 29'h0, 3'h7 - p[2:0]});
            acc(1'b0, p[2:0]);
            acc(1'b1, 3'h7 - p[2:0]);
            acc(1'b0, p[2:0]);
        end
        // lane 0 off, or an unmapped place: write ignored
        pstrb <= 4'hE;
        wr_page(sram_page_pkg::normal_page_addr, 3'h2);
        pstrb <= 4'hF;
        apb(1'b1, 12'h3FC, 32'h0000_0002, {2'b01, 32'h0});
        apb(1'b0, ba(sram_page_pkg::normal_page_addr), 32'h0, {2'b10, 32'h0000_0007});
        // second reset brings pointer and mode back
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ba(sram_page_pkg::normal_page_addr), 32'h0,
            {2'b10, 29'h0, sram_page_pkg::page_reset});
        apb(1'b0, ba(sram_page_pkg::ctrl_addr), 32'h0,
            {2'b10, 31'h0, sram_page_pkg::ctrl_multi_reset});
        acc(1'b0, sram_page_pkg::sole_page);
        // unmapped place refuses and reads zero
        apb(1'b0, 12'h3FC, 32'h0, {2'b11, 32'h0});
        access_valid <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("pending", 0, rd_q.size() + ad_q.size())
        tally_and_finish;
    end
endmodule : sram_page_select_tb_top

// [src/page_mux.sv]
// page selection and sram address forming
`timescale 1ns/1ps
module page_mux (
    // page pointers and mode
    input wire logic [2:0] normal_page,
    input wire logic [2:0] stack_page,
    input wire logic multi_page,
    // access request
    input wire logic stack_access,
    input wire logic [7:0] offset,
    // result
    output logic [10:0] sram_addr
);
    logic [2:0] page;

    always_comb
    begin
        // R03: single page ignores pointer
        // R04: single page ignores stack pointer
        if (!multi_page)
            page = sram_page_pkg::sole_page;
        // R02: stack uses stack field
        else if (stack_access)
            page = stack_page;
        // R01: ordinary uses normal field
        else
            page = normal_page;
        // R06: page above offset
        sram_addr = {page, offset};
    end
endmodule : page_mux

// [src/sram_page_pkg.sv]
// constants for the sram page select register bank
package sram_page_pkg;
    // ----------------------------------------------------------------
    // register map (word indices; byte address is index times scale)
    // ----------------------------------------------------------------
    localparam logic [11:0] normal_page_addr = 12'h0D0;
    localparam logic [11:0] stack_page_addr = 12'h0D1;
    localparam logic [11:0] page_index_scale = 12'h004;
    localparam logic [11:0] ctrl_addr = 12'h0E0;
    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int page_width = 3;
    localparam int offset_width = 8;
    localparam int addr_width = page_width + offset_width;
    localparam logic [2:0] page_reset = 3'h0;
    localparam logic [31:0] read_zero = 32'h0000_0000;
    localparam int ctrl_multi_bit = 0;
    localparam logic ctrl_multi_reset = 1'h0;
    localparam logic [2:0] sole_page = 3'h0;
endpackage : sram_page_pkg

// [src/sram_page_select.sv]
// apb register bank holding the normal and stack sram page pointers
// Function
// R01: ordinary sram accesses go to the page in the normal field
// R02: stack accesses go to the page in the stack field
// R03: normal field only matters when more than one page exists
// R04: stack field only matters when more than one page exists
// R05: software writes zero into unused upper register bits
// R06: sram address is selected page above the 8-bit offset
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module sram_page_select (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sram access path
    input wire logic access_valid,
    input wire logic stack_access,
    input wire logic [7:0] access_offset,
    output logic [10:0] sram_addr,
    output logic sram_addr_valid
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] normal_page_select;
    logic [2:0] stack_page_select;
    logic multi_page;
    logic [10:0] next_sram_addr;
    logic setup;
    logic wr;
    logic hit;
    logic sel_normal;
    logic sel_stack;
    logic sel_ctrl;

    // offsets are word indices; the bus carries byte addresses
    function automatic logic [11:0] byte_addr(input logic [11:0] idx);
        byte_addr = 12'(idx * sram_page_pkg::page_index_scale);
    endfunction : byte_addr

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign sel_normal = (paddr == byte_addr(sram_page_pkg::normal_page_addr));
    assign sel_stack = (paddr == byte_addr(sram_page_pkg::stack_page_addr));
    assign sel_ctrl = (paddr == byte_addr(sram_page_pkg::ctrl_addr));
    assign hit = sel_normal || sel_stack || sel_ctrl;

    // no wait state: setup cycle raises pready, access completes next edge
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite && hit && pstrb[0];

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= sram_page_pkg::read_zero;
        end
        else if (clk_en)
        begin
            pready <= setup;
            pslverr <= setup && !hit;
            prdata <= sram_page_pkg::read_zero;
            if (setup && !pwrite)
            begin
                // upper bits read as zero
                if (sel_normal)
                    prdata <= {29'h0000000, normal_page_select};
                else if (sel_stack)
                    prdata <= {29'h0000000, stack_page_select};
                else if (sel_ctrl)
                    prdata <= {31'h00000000, multi_page};
                else
                    prdata <= sram_page_pkg::read_zero;
            end
        end
    end

    // ------------------------------------------------------------
    // page registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            normal_page_select <= sram_page_pkg::page_reset;
            stack_page_select <= sram_page_pkg::page_reset;
            multi_page <= sram_page_pkg::ctrl_multi_reset;
        end
        else if (clk_en && wr)
        begin
            // R05: upper bits are dropped, software writes them zero
            // unmapped places and lane 0 off never reach here
            if (sel_normal)
                normal_page_select <= pwdata[2:0];
            else if (sel_stack)
                stack_page_select <= pwdata[2:0];
            else if (sel_ctrl)
                multi_page <= pwdata[sram_page_pkg::ctrl_multi_bit];
        end
    end

    // ------------------------------------------------------------
    // address path
    // ------------------------------------------------------------
    // R06: concatenate page and offset
    page_mux page_mux_inst (
        .normal_page(normal_page_select),
        .stack_page(stack_page_select),
        .multi_page(multi_page),
        .stack_access(stack_access),
        .offset(access_offset),
        .sram_addr(next_sram_addr)
    );

    // registered so the output is a flop; costs one cycle of latency
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sram_addr <= 11'h000;
            sram_addr_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            sram_addr <= next_sram_addr;
            sram_addr_valid <= access_valid;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // R01: normal access uses normal page when multi
    normal_route_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        clk_en && access_valid && !stack_access && multi_page
        |=> sram_addr[10:8] == $past(normal_page_select))
        else $error("normal access on wrong page");
    // R02: stack access uses stack page when multi
    stack_route_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        clk_en && access_valid && stack_access && multi_page
        |=> sram_addr[10:8] == $past(stack_page_select))
        else $error("stack access on wrong page");
    // R03: single page ignores normal pointer
    single_normal_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        clk_en && access_valid && !stack_access && !multi_page
        |=> sram_addr[10:8] == sram_page_pkg::sole_page)
        else $error("single page normal access not page 0");
    // R04: single page ignores stack pointer
    single_stack_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        clk_en && access_valid && stack_access && !multi_page
        |=> sram_addr[10:8] == sram_page_pkg::sole_page)
        else $error("single page stack access not page 0");
    // R06: offset lands in low bits
    offset_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        clk_en && access_valid
        |=> sram_addr[7:0] == $past(access_offset))
        else $error("offset not in low address bits");
    // R01: written normal page value held
    write_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        clk_en && wr && sel_normal
        |=> normal_page_select == $past(pwdata[2:0]))
        else $error("normal page write lost");
    // R02: written stack page value held
    stack_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        clk_en && wr && sel_stack
        |=> stack_page_select == $past(pwdata[2:0]))
        else $error("stack page write lost");
    // R01: normal page reads back
    normal_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        clk_en && setup && !pwrite && sel_normal
        |=> prdata == {29'h0000000, $past(normal_page_select)})
        else $error("normal page read wrong");
    // R02: stack page reads back
    stack_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        clk_en && setup && !pwrite && sel_stack
        |=> prdata == {29'h0000000, $past(stack_page_select)})
        else $error("stack page read wrong");
    // answer comes one cycle after setup
    ready_after_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && setup
        |=> pready)
        else $error("pready missing after setup");
    // pready stands for one cycle only
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pready
        |=> !pready)
        else $error("pready held too long");
    // error flag only for unmapped places
    error_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && setup
        |=> pslverr == !$past(hit))
        else $error("pslverr does not match decode");
    // unmapped write leaves every register alone
    unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && !hit
        |=> $stable(normal_page_select) && $stable(stack_page_select) && $stable(multi_page))
        else $error("unmapped write changed a register");
    // write with lane 0 off is ignored
    strobe_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pready && pwrite && !pstrb[0]
        |=> $stable(normal_page_select) && $stable(stack_page_select) && $stable(multi_page))
        else $error("write without lane 0 changed a register");
    // valid flag follows the request by one cycle
    valid_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en
        |=> sram_addr_valid == $past(access_valid))
        else $error("sram_addr_valid out of step");
endmodule : sram_page_select
